// ### inc/flc_params.svh
// constants of the fast ethernet line coder: symbols, levels, frame sizes and timing
`ifndef FLC_PARAMS_SVH
`define FLC_PARAMS_SVH

// control symbols
`define FLC_SYM_IDLE 5'h1f
`define FLC_SYM_SSD1 5'h18
`define FLC_SYM_SSD2 5'h11
`define FLC_SYM_ESD1 5'h0d
`define FLC_SYM_ESD2 5'h07
`define FLC_SYM_HALT 5'h04
`define FLC_NIB_SSD 4'h5

// serial position of the last bit of a symbol (msb goes first)
`define FLC_SYM_LAST 3'h4

// two-bit line levels for the analog driver
`define FLC_MLT_LOW 2'h0
`define FLC_MLT_MID 2'h1
`define FLC_MLT_HIGH 2'h2

// scrambler taps of the 11-bit self-synchronising polynomial
`define FLC_SCR_TAP_A 10
`define FLC_SCR_TAP_B 8

// clock cycles per serial symbol bit
`define FLC_BIT_DIV 8'h01

// frame layout in octets
`define FLC_PRE_OCT 12'h008
`define FLC_DA_OCT 12'h006
`define FLC_SA_OCT 12'h006
`define FLC_LEN_OCT 12'h002
`define FLC_PAY_MIN_OCT 12'h02e
`define FLC_PAY_MAX_OCT 12'h5dc
`define FLC_FCS_OCT 12'h004

`endif

// ### inc/flc_pkg.sv
// types of the fast ethernet line coder
package flc_pkg;

  // nibble stream from the media access side
  typedef struct packed {
    logic en;
    logic err;
    logic [3:0] nibble;
  } flc_tx_s;

  // nibble stream toward the media access side
  typedef struct packed {
    logic dv;
    logic valid;
    logic [3:0] nibble;
    logic err;
    logic lenErr;
  } flc_rx_s;

  typedef enum logic [5:0] {
    TS_IDLE = 6'h01,
    TS_SSD1 = 6'h02,
    TS_SSD2 = 6'h04,
    TS_DATA = 6'h08,
    TS_ESD1 = 6'h10,
    TS_ESD2 = 6'h20
  } flc_tx_state_e;

  typedef enum logic [2:0] {
    RS_HUNT = 3'h1,
    RS_FRAME = 3'h2,
    RS_ENDCHK = 3'h4
  } flc_rx_state_e;

endpackage

// ### tb/flc_line_coder_properties.sv
// assertions on the ports of the line coder
`timescale 1ns/1ps
`include "flc_params.svh"

module flc_line_coder_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic tpModePin,
  input wire flc_pkg::flc_tx_s txIn,
  input wire logic txTake,
  input wire logic txNrzi,
  input wire logic [1:0] txMlt3Lvl,
  input wire logic rxLinePin,
  input wire flc_pkg::flc_rx_s rxOut
);
  logic [1:0] lastOuter_ff;
  logic [1:0] nxt_lastOuter;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ----------------
  // helper state
  // ----------------
  // remembers the outer level last left, so a step out of middle must go the other way
  always_comb begin
    nxt_lastOuter = lastOuter_ff;
    if (!rst_b) nxt_lastOuter = `FLC_MLT_LOW;
    else if (txMlt3Lvl != `FLC_MLT_MID) nxt_lastOuter = txMlt3Lvl;
  end

  always_ff @(posedge core_clk) begin
    lastOuter_ff <= nxt_lastOuter;
  end

  // ----------------
  // assertions
  // ----------------
  chk_take_gap: assert property (txTake |=> !txTake [*4])
    else $error("transmit took nibbles closer than one symbol");
  chk_take_en: assert property (txTake |-> txIn.en)
    else $error("transmit took a nibble outside a frame");
  chk_mlt_legal: assert property (txMlt3Lvl != 2'h3)
    else $error("line level code out of range");
  chk_mlt_outer: assert property ($changed(txMlt3Lvl) && $past(txMlt3Lvl) != `FLC_MLT_MID
    |-> txMlt3Lvl == `FLC_MLT_MID)
    else $error("line level skipped middle");
  chk_mlt_alt: assert property ($changed(txMlt3Lvl) && $past(txMlt3Lvl) == `FLC_MLT_MID
    |-> txMlt3Lvl != lastOuter_ff)
    else $error("line level did not alternate direction");
  chk_fiber_mid: assert property (!tpModePin [*6] |-> txMlt3Lvl == `FLC_MLT_MID)
    else $error("line level moved in fiber mode");
  chk_valid_dv: assert property (rxOut.valid |-> rxOut.dv)
    else $error("receive nibble outside a frame");
  chk_start_pair: assert property ($rose(rxOut.dv) |-> (rxOut.valid && rxOut.nibble == 4'h5)
    ##1 (rxOut.valid && rxOut.nibble == 4'h5))
    else $error("frame start did not report two start nibbles");
  chk_dv_clear: assert property ($rose(rxOut.dv) |-> !rxOut.err && !rxOut.lenErr)
    else $error("frame flags not cleared at frame start");
  chk_err_hold: assert property ($fell(rxOut.err) |-> $rose(rxOut.dv))
    else $error("frame error dropped outside a frame start");
  chk_len_hold: assert property ($fell(rxOut.lenErr) |-> $rose(rxOut.dv))
    else $error("length error dropped outside a frame start");

  cover property ($rose(rxOut.dv));
  cover property ($rose(rxOut.err));
  cover property ($rose(rxOut.lenErr));
  cover property ($changed(txMlt3Lvl));
endmodule

bind flc_line_coder flc_line_coder_checker chk (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .tpModePin(tpModePin),
  .txIn(txIn),
  .txTake(txTake),
  .txNrzi(txNrzi),
  .txMlt3Lvl(txMlt3Lvl),
  .rxLinePin(rxLinePin),
  .rxOut(rxOut)
);

// ### tb/flc_line_model.sv
// line model on the far side: loops the transmit line back or sends injected symbol bits
`timescale 1ns/1ps

module flc_line_model (
  input wire logic core_clk,
  input wire logic loopEn,
  input wire logic txNrzi,
  input wire logic injBit,
  output logic rxLinePin
);
  logic lineLvl_ff = 1'b0;

  // injected bits leave as nrzi: a one toggles the line, a zero holds it
  always @(posedge core_clk) begin
    lineLvl_ff <= loopEn ? txNrzi : lineLvl_ff ^ injBit;
  end

  assign rxLinePin = lineLvl_ff;
endmodule

// ### tb/test_flc_line_coder.sv
// testbench of the line coder: frames in both modes, bad symbols and line levels
`timescale 1ns/1ps
`include "flc_params.svh"

module test_flc_line_coder;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic tpModePin = 1'b0;
  logic loopEn = 1'b1;
  logic injBit = 1'b1;
  flc_pkg::flc_tx_s txIn = '0;
  logic txTake;
  logic txNrzi;
  logic rxLinePin;
  logic [1:0] txMlt3Lvl;
  flc_pkg::flc_rx_s rxOut;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int mltChanges = 0;
  logic prevNrzi = 1'b0;
  logic [1:0] lastLvl = 2'h1;
  logic [1:0] lastOuter = 2'h0;
  logic [1:0] expLvl;
  logic txBits[$];
  logic [3:0] rxQ[$];
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  flc_line_coder dut (.core_clk(core_clk), .rst_b(rst_b), .tpModePin(tpModePin), .txIn(txIn),
    .txTake(txTake), .txNrzi(txNrzi), .txMlt3Lvl(txMlt3Lvl), .rxLinePin(rxLinePin),
    .rxOut(rxOut));
  flc_line_model line (.core_clk(core_clk), .loopEn(loopEn), .txNrzi(txNrzi), .injBit(injBit),
    .rxLinePin(rxLinePin));

  initial forever #10 core_clk = ~core_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------
  // monitors
  // ----------------
  // sampled on the falling edge so registered outputs have settled
  always @(negedge core_clk) begin
    txBits.push_back(txNrzi ^ prevNrzi);
    prevNrzi = txNrzi;
    if (rxOut.valid === 1'b1) rxQ.push_back(rxOut.nibble);
    if (!rst_b) begin
      lastLvl = 2'h1;
      lastOuter = 2'h0;
    end else if (txMlt3Lvl !== lastLvl) begin
      expLvl = (lastLvl != 2'h1) ? 2'h1 : ((lastOuter == 2'h0) ? 2'h2 : 2'h0);
      check(16'(txMlt3Lvl), 16'(expLvl));
      if (lastLvl != 2'h1) lastOuter = lastLvl;
      lastLvl = txMlt3Lvl;
      mltChanges++;
    end
  end

  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      test_done;
    end
  end

  function automatic logic [4:0] symAt(input int p);
    return {txBits[p], txBits[p + 1], txBits[p + 2], txBits[p + 3], txBits[p + 4]};
  endfunction

  // ----------------
  // scenarios
  // ----------------
  task automatic idleFiber;
    txBits.delete();
    repeat (20) @(posedge core_clk);
    foreach (txBits[j]) check(16'(txBits[j]), 16'h1);
  endtask

  task automatic runFrame(input int n, input int errAt, input logic expLen);
    int i;
    int k;
    int p;
    int j;
    logic tk;
    txBits.delete();
    rxQ.delete();
    // give the captured stream a full scrambler history before the frame starts
    repeat (12) @(posedge core_clk);
    i = 0;
    txIn <= '{en: 1'b1, err: 1'b0, nibble: 4'h5};
    while (i < n) begin
      @(negedge core_clk);
      tk = txTake;
      @(posedge core_clk);
      if (tk) begin
        i++;
        txIn <= '{en: i < n, err: i == errAt, nibble: (i < 2) ? 4'h5 : i[3:0]};
      end
    end
    repeat (60) @(posedge core_clk);
    check(16'(rxQ.size()), 16'((errAt < 0) ? n : n - 1));
    k = 0;
    for (i = 0; i < n; i++) if (i != errAt) begin
      check(16'(rxQ[k]), 16'((i < 2) ? 4'h5 : i[3:0]));
      k++;
    end
    check(16'({rxOut.dv, rxOut.err, rxOut.lenErr}), 16'({1'b0, errAt >= 0, expLen}));
    // twisted pair: strip the line scrambler so the same symbol checks apply;
    // walk backwards so every tap still reads the bit as it was sent
    if (tpModePin) begin
      for (j = txBits.size() - 1; j > `FLC_SCR_TAP_A; j--)
        txBits[j] = txBits[j] ^ txBits[j - 1 - `FLC_SCR_TAP_A] ^ txBits[j - 1 - `FLC_SCR_TAP_B];
    end
    p = 0;
    while (p < 200 && {symAt(p), symAt(p + 5)} !== 10'h311) p++;
    check(16'({symAt(p), symAt(p + 5)}), 16'h0311);
    for (i = 2; i < n; i++)
      check(16'(symAt(p + 5 * i)), 16'((i == errAt) ? 5'h04 : ENC[i[3:0]]));
    p = p + 5 * n;
    check(16'({symAt(p), symAt(p + 5), symAt(p + 10)}), 16'h34ff);
    if (!tpModePin) check(16'(txMlt3Lvl), 16'h0001);
  endtask

  task automatic injectBad;
    logic [4:0] syms [14] = '{5'h1f, 5'h1f, 5'h18, 5'h11, 5'h1e, 5'h00, 5'h09, 5'h19, 5'h03,
      5'h04, 5'h0d, 5'h07, 5'h1f, 5'h1f};
    loopEn <= 1'b0;
    rxQ.delete();
    foreach (syms[s]) for (int b = 4; b >= 0; b--) begin
      @(posedge core_clk);
      injBit <= syms[s][b];
    end
    repeat (20) @(posedge core_clk);
    check(16'(rxQ.size()), 16'h0004);
    check(16'({rxQ[0], rxQ[1], rxQ[2], rxQ[3]}), 16'h5501);
    check(16'({rxOut.dv, rxOut.err, rxOut.lenErr}), 16'h0003);
    loopEn <= 1'b1;
  endtask

  initial begin
    @(negedge core_clk);
    check(16'({txNrzi, txMlt3Lvl, rxOut}), 16'h0100);
    @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (30) @(posedge core_clk);
    idleFiber;
    runFrame(144, -1, 1'b0);
    runFrame(142, -1, 1'b1);
    runFrame(143, -1, 1'b1);
    runFrame(40, 9, 1'b1);
    runFrame(3052, -1, 1'b0);
    runFrame(3054, -1, 1'b1);
    injectBad;
    tpModePin <= 1'b1;
    repeat (60) @(posedge core_clk);
    runFrame(144, -1, 1'b0);
    check(16'(mltChanges > 20), 16'h0001);
    test_done;
  end
endmodule

// ### verilog/flc_line_coder.sv
// transmit 4b/5b, nrzi and three-level line coding and receive nrzi and 4b/5b decoding path of a 100 Mb/s port
`timescale 1ns/1ps
`include "flc_params.svh"

module flc_line_coder (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic tpModePin,
  input wire flc_pkg::flc_tx_s txIn,
  output logic txTake,
  output logic txNrzi,
  output logic [1:0] txMlt3Lvl,
  input wire logic rxLinePin,
  output flc_pkg::flc_rx_s rxOut
);

  // ----------------------------------------------------------------
  // code tables
  // ----------------------------------------------------------------
  function automatic logic [4:0] encNibble(input logic [3:0] nib);
    logic [4:0] sym;
    sym = `FLC_SYM_IDLE;
    case (nib)
      4'h0: sym = 5'h1e;
      4'h1: sym = 5'h09;
      4'h2: sym = 5'h14;
      4'h3: sym = 5'h15;
      4'h4: sym = 5'h0a;
      4'h5: sym = 5'h0b;
      4'h6: sym = 5'h0e;
      4'h7: sym = 5'h0f;
      4'h8: sym = 5'h12;
      4'h9: sym = 5'h13;
      4'ha: sym = 5'h16;
      4'hb: sym = 5'h17;
      4'hc: sym = 5'h1a;
      4'hd: sym = 5'h1b;
      4'he: sym = 5'h1c;
      default: sym = 5'h1d;
    endcase
    return sym;
  endfunction

  // returns {isData, nibble}; control and invalid symbols give isData low
  function automatic logic [4:0] decSymbol(input logic [4:0] sym);
    logic [4:0] res;
    res = 5'h00;
    case (sym)
      5'h1e: res = 5'h10;
      5'h09: res = 5'h11;
      5'h14: res = 5'h12;
      5'h15: res = 5'h13;
      5'h0a: res = 5'h14;
      5'h0b: res = 5'h15;
      5'h0e: res = 5'h16;
      5'h0f: res = 5'h17;
      5'h12: res = 5'h18;
      5'h13: res = 5'h19;
      5'h16: res = 5'h1a;
      5'h17: res = 5'h1b;
      5'h1a: res = 5'h1c;
      5'h1b: res = 5'h1d;
      5'h1c: res = 5'h1e;
      5'h1d: res = 5'h1f;
      default: res = 5'h00;
    endcase
    return res;
  endfunction

  // self-synchronising scrambler feedback, shared by both directions
  function automatic logic scrTap(input logic [10:0] sr);
    return sr[`FLC_SCR_TAP_A] ^ sr[`FLC_SCR_TAP_B];
  endfunction

  // ----------------------------------------------------------------
  // bit-rate enable and input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] divCnt_ff, nxt_divCnt;
  logic bitEn;
  logic tpS1_ff, tpS2_ff, rxS1_ff, rxS2_ff;

  assign bitEn = (divCnt_ff == (`FLC_BIT_DIV - 8'h01));

  always_comb begin
    nxt_divCnt = bitEn ? 8'h00 : divCnt_ff + 8'h01;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      divCnt_ff <= 8'h00;
      tpS1_ff <= 1'b0;
      tpS2_ff <= 1'b0;
      rxS1_ff <= 1'b0;
      rxS2_ff <= 1'b0;
    end else begin
      divCnt_ff <= nxt_divCnt;
      tpS1_ff <= tpModePin;
      tpS2_ff <= tpS1_ff;
      rxS1_ff <= rxLinePin;
      rxS2_ff <= rxS1_ff;
    end
  end

  // ----------------------------------------------------------------
  // transmit symbol sequencer
  // ----------------------------------------------------------------
  flc_pkg::flc_tx_state_e txState_ff, nxt_txState;
  logic [4:0] txSh_ff, nxt_txSh;
  logic [2:0] txCnt_ff, nxt_txCnt;
  logic txBit;

  // the mac presents its frame from the first preamble nibble; the first two
  // nibbles are swallowed by the start pair
  always_comb begin
    nxt_txState = txState_ff;
    nxt_txSh = txSh_ff;
    nxt_txCnt = txCnt_ff;
    txTake = 1'b0;
    if (bitEn) begin
      if (txCnt_ff == `FLC_SYM_LAST) begin
        nxt_txCnt = 3'h0;
        case (txState_ff)
          flc_pkg::TS_SSD1: begin
            nxt_txSh = `FLC_SYM_SSD2;
            txTake = 1'b1;
            nxt_txState = flc_pkg::TS_SSD2;
          end
          flc_pkg::TS_SSD2, flc_pkg::TS_DATA: begin
            if (txIn.en) begin
              nxt_txSh = txIn.err ? `FLC_SYM_HALT : encNibble(txIn.nibble);
              txTake = 1'b1;
              nxt_txState = flc_pkg::TS_DATA;
            end else begin
              nxt_txSh = `FLC_SYM_ESD1;
              nxt_txState = flc_pkg::TS_ESD1;
            end
          end
          flc_pkg::TS_ESD1: begin
            nxt_txSh = `FLC_SYM_ESD2;
            nxt_txState = flc_pkg::TS_ESD2;
          end
          default: begin
            if (txIn.en) begin
              nxt_txSh = `FLC_SYM_SSD1;
              txTake = 1'b1;
              nxt_txState = flc_pkg::TS_SSD1;
            end else begin
              nxt_txSh = `FLC_SYM_IDLE;
              nxt_txState = flc_pkg::TS_IDLE;
            end
          end
        endcase
      end else begin
        nxt_txSh = {txSh_ff[3:0], 1'b0};
        nxt_txCnt = txCnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      txState_ff <= flc_pkg::TS_IDLE;
      txSh_ff <= `FLC_SYM_IDLE;
      txCnt_ff <= 3'h0;
    end else begin
      txState_ff <= nxt_txState;
      txSh_ff <= nxt_txSh;
      txCnt_ff <= nxt_txCnt;
    end
  end

  assign txBit = txSh_ff[4];

  // ----------------------------------------------------------------
  // transmit line coder
  // ----------------------------------------------------------------
  logic [10:0] scr_ff, nxt_scr;
  logic nrzi_ff, nxt_nrzi, mltUp_ff, nxt_mltUp, scrBit;
  logic [1:0] mlt_ff, nxt_mlt;

  // fiber mode sends the plain symbol stream as nrzi and parks the three-level
  // output at middle, so the driver sees no activity on the unused path
  always_comb begin
    scrBit = txBit ^ (tpS2_ff & scrTap(scr_ff));
    nxt_scr = scr_ff;
    nxt_nrzi = nrzi_ff;
    nxt_mlt = mlt_ff;
    nxt_mltUp = mltUp_ff;
    if (bitEn) begin
      nxt_scr = {scr_ff[9:0], scrBit};
      nxt_nrzi = nrzi_ff ^ scrBit;
      if (!tpS2_ff) begin
        nxt_mlt = `FLC_MLT_MID;
        nxt_mltUp = 1'b1;
      end else if (scrBit) begin
        case (mlt_ff)
          `FLC_MLT_LOW: begin
            nxt_mlt = `FLC_MLT_MID;
            nxt_mltUp = 1'b1;
          end
          `FLC_MLT_HIGH: begin
            nxt_mlt = `FLC_MLT_MID;
            nxt_mltUp = 1'b0;
          end
          default: nxt_mlt = mltUp_ff ? `FLC_MLT_HIGH : `FLC_MLT_LOW;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      scr_ff <= 11'h000;
      nrzi_ff <= 1'b0;
      mlt_ff <= `FLC_MLT_MID;
      mltUp_ff <= 1'b1;
    end else begin
      scr_ff <= nxt_scr;
      nrzi_ff <= nxt_nrzi;
      mlt_ff <= nxt_mlt;
      mltUp_ff <= nxt_mltUp;
    end
  end

  assign txNrzi = nrzi_ff;
  assign txMlt3Lvl = mlt_ff;

  // ----------------------------------------------------------------
  // receive decoder
  // ----------------------------------------------------------------
  flc_pkg::flc_rx_state_e rxState_ff, nxt_rxState;
  logic rxPrev_ff, nxt_rxPrev, extra_ff, nxt_extra, rawBit, plainBit;
  logic [10:0] dsc_ff, nxt_dsc;
  logic [9:0] win_ff, nxt_win;
  logic [2:0] rxCnt_ff, nxt_rxCnt;
  logic [11:0] nibCnt_ff, nxt_nibCnt, octCnt, octMin, octMax;
  logic [4:0] decRes;
  flc_pkg::flc_rx_s rxOut_ff, nxt_rxOut;

  assign octMin = `FLC_PRE_OCT + `FLC_DA_OCT + `FLC_SA_OCT + `FLC_LEN_OCT
                  + `FLC_PAY_MIN_OCT + `FLC_FCS_OCT;
  assign octMax = `FLC_PRE_OCT + `FLC_DA_OCT + `FLC_SA_OCT + `FLC_LEN_OCT
                  + `FLC_PAY_MAX_OCT + `FLC_FCS_OCT;
  assign octCnt = {1'b0, nibCnt_ff[11:1]};

  always_comb begin
    rawBit = rxS2_ff ^ rxPrev_ff;
    plainBit = rawBit ^ (tpS2_ff & scrTap(dsc_ff));
    nxt_rxPrev = rxPrev_ff;
    nxt_dsc = dsc_ff;
    nxt_win = win_ff;
    nxt_rxState = rxState_ff;
    nxt_rxCnt = rxCnt_ff;
    nxt_nibCnt = nibCnt_ff;
    nxt_extra = extra_ff;
    nxt_rxOut = rxOut_ff;
    nxt_rxOut.valid = 1'b0;
    decRes = decSymbol(nxt_win[4:0]);
    if (bitEn) begin
      nxt_rxPrev = rxS2_ff;
      nxt_dsc = {dsc_ff[9:0], rawBit};
      nxt_win = {win_ff[8:0], plainBit};
      decRes = decSymbol(nxt_win[4:0]);
      nxt_rxCnt = rxCnt_ff + 3'h1;
      if (extra_ff) begin
        nxt_extra = 1'b0;
        nxt_rxOut.valid = 1'b1;
        nxt_rxOut.nibble = `FLC_NIB_SSD;
      end
      case (rxState_ff)
        flc_pkg::RS_HUNT: begin
          if (nxt_win == {`FLC_SYM_SSD1, `FLC_SYM_SSD2}) begin
            nxt_rxState = flc_pkg::RS_FRAME;
            nxt_rxCnt = 3'h0;
            nxt_nibCnt = 12'h002;
            nxt_extra = 1'b1;
            nxt_rxOut.dv = 1'b1;
            nxt_rxOut.valid = 1'b1;
            nxt_rxOut.nibble = `FLC_NIB_SSD;
            nxt_rxOut.err = 1'b0;
            nxt_rxOut.lenErr = 1'b0;
          end
        end
        flc_pkg::RS_FRAME: begin
          if (rxCnt_ff == `FLC_SYM_LAST) begin
            nxt_rxCnt = 3'h0;
            if (decRes[4]) begin
              nxt_rxOut.valid = 1'b1;
              nxt_rxOut.nibble = decRes[3:0];
              if (nibCnt_ff != 12'hfff) begin
                nxt_nibCnt = nibCnt_ff + 12'h001;
              end
            end else if (nxt_win[4:0] == `FLC_SYM_ESD1) begin
              nxt_rxState = flc_pkg::RS_ENDCHK;
            end else if (nxt_win[4:0] == `FLC_SYM_IDLE) begin
              // idle before the end pair: frame cut short
              nxt_rxState = flc_pkg::RS_HUNT;
              nxt_rxOut.dv = 1'b0;
              nxt_rxOut.err = 1'b1;
            end else begin
              nxt_rxOut.err = 1'b1;
            end
          end
        end
        default: begin
          if (rxCnt_ff == `FLC_SYM_LAST) begin
            nxt_rxCnt = 3'h0;
            nxt_rxState = flc_pkg::RS_HUNT;
            nxt_rxOut.dv = 1'b0;
            if (nxt_win[4:0] != `FLC_SYM_ESD2) begin
              nxt_rxOut.err = 1'b1;
            end
            // length is judged on whole octets from preamble to check field
            if (nibCnt_ff[0] || octCnt < octMin || octCnt > octMax) begin
              nxt_rxOut.lenErr = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rxState_ff <= flc_pkg::RS_HUNT;
      rxPrev_ff <= 1'b0;
      dsc_ff <= 11'h000;
      win_ff <= 10'h000;
      rxCnt_ff <= 3'h0;
      nibCnt_ff <= 12'h000;
      extra_ff <= 1'b0;
      rxOut_ff <= '0;
    end else begin
      rxState_ff <= nxt_rxState;
      rxPrev_ff <= nxt_rxPrev;
      dsc_ff <= nxt_dsc;
      win_ff <= nxt_win;
      rxCnt_ff <= nxt_rxCnt;
      nibCnt_ff <= nxt_nibCnt;
      extra_ff <= nxt_extra;
      rxOut_ff <= nxt_rxOut;
    end
  end

  assign rxOut = rxOut_ff;

endmodule
